// file: verilog/daa_link_init.sv
// System-side link, register file and line control of the modem line interface
module daa_link_init
	import daa_link_pkg::*;
#(
	parameter int SETTLE_SAMPLES = OFFHOOK_SAMPLES
)
(
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_BIT_CLK,
	input  wire logic        I_SYNC,
	input  wire logic        I_SDATA_OUT,
	input  wire logic        I_LINE_TWO,
	input  wire logic        I_LINE_RX_VALID,
	input  wire logic [15:0] I_LINE_RX_DATA,
	output logic             O_LINE_RX_READY,
	output logic             O_SDATA_IN,
	output logic             O_LINE_POWERED,
	output logic             O_ISO_LINK_EN,
	output logic             O_OFF_HOOK,
	output logic             O_LINE_DATA_OK,
	output logic [1:0]       O_DC_TERM,
	output logic             O_AC_TERM,
	output logic [1:0]       O_TX_LEVEL,
	output logic             O_LINE_TX_VALID,
	output logic [15:0]      O_LINE_TX_DATA
);
	// ****************************************
	// Pin synchronisers: bit clock, sync, serial data
	// ****************************************
	logic [2:0] s1_reg, s2_reg, s3_reg, filt_reg;
	logic       bclk_rise, bclk_fall, sync_prev_reg, sync_start;

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			s1_reg   <= 3'h0;
			s2_reg   <= 3'h0;
			s3_reg   <= 3'h0;
			filt_reg <= 3'h0;
		end
		else
		begin
			s1_reg   <= {I_SDATA_OUT, I_SYNC, I_BIT_CLK};
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
		end
	end

	assign bclk_rise  = s2_reg[0] && s3_reg[0] && !filt_reg[0];
	assign bclk_fall  = !s2_reg[0] && !s3_reg[0] && filt_reg[0];
	assign sync_start = bclk_rise && filt_reg[1] && !sync_prev_reg;

	// ****************************************
	// Receive framer
	// ****************************************
	logic        line2_reg;
	logic        in_frame_reg;
	logic [3:0]  rx_slot_reg;
	logic [4:0]  rx_bit_reg;
	logic [19:0] rx_sh_reg;
	logic [19:0] rx_word;
	logic        slot_end;
	logic [12:0] rx_tag_reg;
	reg_cmd_t    cmd_reg;
	logic        cmd_go_reg;
	logic        hook_cmd_reg;
	logic        iso_en_reg;
	logic [3:0]  own_slot;

	assign rx_word  = {rx_sh_reg[18:0], filt_reg[2]};
	assign slot_end = bclk_fall && in_frame_reg && (rx_bit_reg == 5'h0);
	assign own_slot = line2_reg ? SLOT_DATA2 : SLOT_DATA1;

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			sync_prev_reg <= 1'b0;
			in_frame_reg  <= 1'b0;
			rx_slot_reg   <= 4'h0;
			rx_bit_reg    <= 5'h0;
			rx_sh_reg     <= 20'h0;
		end
		else
		begin
			if (bclk_rise)
				sync_prev_reg <= filt_reg[1];
			if (sync_start)
			begin
				in_frame_reg <= 1'b1;
				rx_slot_reg  <= 4'h0;
				rx_bit_reg   <= TAG_BITS;
			end
			else if (bclk_fall && in_frame_reg)
			begin
				rx_sh_reg <= rx_word;
				if (rx_bit_reg != 5'h0)
					rx_bit_reg <= rx_bit_reg - 5'h1;
				else if (rx_slot_reg == SLOT_LAST)
					in_frame_reg <= 1'b0;
				else
				begin
					rx_slot_reg <= rx_slot_reg + 4'h1;
					rx_bit_reg  <= SLOT_BITS;
				end
			end
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			rx_tag_reg      <= 13'h0;
			cmd_reg         <= '0;
			cmd_go_reg      <= 1'b0;
			hook_cmd_reg    <= 1'b0;
			O_LINE_TX_VALID <= 1'b0;
			O_LINE_TX_DATA  <= 16'h0;
		end
		else
		begin
			cmd_go_reg      <= 1'b0;
			O_LINE_TX_VALID <= 1'b0;
			if (slot_end)
			begin
				if (rx_slot_reg == 4'h0)
					rx_tag_reg <= rx_word[15:3];
				if (rx_slot_reg == 4'h1 && rx_tag_reg[11])
				begin
					cmd_reg.rd  <= rx_word[19];
					cmd_reg.idx <= rx_word[18:12];
				end
				// Reads need only the address slot tagged; writes need both
				if (rx_slot_reg == 4'h2 && rx_tag_reg[11] && (cmd_reg.rd || rx_tag_reg[10]))
				begin
					cmd_reg.data <= rx_word[19:4];
					cmd_go_reg   <= 1'b1;
				end
				// Samples never cross to the line side before the link is up
				if (rx_slot_reg == own_slot && rx_tag_reg[12 - own_slot] && iso_en_reg)
				begin
					O_LINE_TX_VALID <= 1'b1;
					O_LINE_TX_DATA  <= rx_word[19:4];
				end
				if (rx_slot_reg == SLOT_LAST && rx_tag_reg[0])
					hook_cmd_reg <= line2_reg ? rx_word[HOOK_BIT2] : rx_word[HOOK_BIT1];
			end
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	logic [7:0]  pr_reg;
	logic [15:0] rate1_reg, rate2_reg, level1_reg, level2_reg, term_reg, linelvl_reg;
	logic        soft_reset;
	logic        wr;
	logic [15:0] own_rate;

	assign wr         = cmd_go_reg && !cmd_reg.rd;
	assign soft_reset = wr && (cmd_reg.idx == REG_RESET_IDX);
	assign own_rate   = line2_reg ? rate2_reg : rate1_reg;

	// Strap is held static by the board while reset is asserted
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			line2_reg <= I_LINE_TWO;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST || soft_reset)
		begin
			pr_reg      <= PR_RESET;
			rate1_reg   <= RATE_RESET;
			rate2_reg   <= RATE_RESET;
			level1_reg  <= LEVEL_RESET;
			level2_reg  <= LEVEL_RESET;
			term_reg    <= TERM_RESET;
			linelvl_reg <= LINELVL_RESET;
		end
		else if (wr)
		begin
			unique case (cmd_reg.idx)
				REG_POWER_IDX:   pr_reg      <= cmd_reg.data[15:8];
				REG_RATE1_IDX:   rate1_reg   <= cmd_reg.data;
				REG_RATE2_IDX:   rate2_reg   <= cmd_reg.data;
				REG_LEVEL1_IDX:  level1_reg  <= cmd_reg.data;
				REG_LEVEL2_IDX:  level2_reg  <= cmd_reg.data;
				REG_LINELVL_IDX: linelvl_reg <= cmd_reg.data;
				REG_TERM_IDX:
				begin
					// Code 00 names no termination mode, so the field keeps its value
					term_reg <= cmd_reg.data[DCT_LSB +: 2] == 2'h0 ?
						{cmd_reg.data[15:4], term_reg[3:2], cmd_reg.data[1:0]} :
						cmd_reg.data;
				end
				default: ;
			endcase
		end
	end

	function automatic logic [15:0] read_word(input logic [6:0] idx);
		logic [15:0] w;
		w = 16'h0;
		unique case (idx)
			REG_POWER_IDX:   w = {pr_reg, iso_en_reg ? (line2_reg ? READY_LINE2 : READY_LINE1)
				: 8'h00};
			REG_RATE1_IDX:   w = rate1_reg;
			REG_RATE2_IDX:   w = rate2_reg;
			REG_LEVEL1_IDX:  w = level1_reg;
			REG_LEVEL2_IDX:  w = level2_reg;
			REG_TERM_IDX:    w = term_reg;
			REG_LINELVL_IDX: w = linelvl_reg;
			default:         w = 16'h0;
		endcase
		return w;
	endfunction

	// ****************************************
	// Line-side control
	// ****************************************
	logic [27:0] phase_reg;
	logic        smp_tick_reg;
	logic [10:0] settle_reg;

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			iso_en_reg     <= 1'b0;
			O_ISO_LINK_EN  <= 1'b0;
			O_LINE_POWERED <= 1'b0;
			O_OFF_HOOK     <= 1'b0;
			O_DC_TERM      <= DCT_FCC;
			O_AC_TERM      <= 1'b0;
			O_TX_LEVEL     <= 2'h0;
		end
		else
		begin
			iso_en_reg     <= (pr_reg == 8'h00) && (own_rate != 16'h0);
			O_ISO_LINK_EN  <= (pr_reg == 8'h00) && (own_rate != 16'h0);
			O_LINE_POWERED <= (pr_reg == 8'h00);
			O_OFF_HOOK     <= hook_cmd_reg && iso_en_reg;
			O_DC_TERM      <= term_reg[DCT_LSB +: 2];
			O_AC_TERM      <= term_reg[ACT_BIT];
			O_TX_LEVEL     <= linelvl_reg[VOL_LSB +: 2];
		end
	end

	// Sample ticks come from a phase accumulator, so any programmed rate is followed
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			phase_reg    <= 28'h0;
			smp_tick_reg <= 1'b0;
		end
		else if (phase_reg + {12'h0, own_rate} >= CLK_HZ_W)
		begin
			phase_reg    <= phase_reg + {12'h0, own_rate} - CLK_HZ_W;
			smp_tick_reg <= 1'b1;
		end
		else
		begin
			phase_reg    <= phase_reg + {12'h0, own_rate};
			smp_tick_reg <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST || !O_OFF_HOOK)
		begin
			settle_reg     <= 11'h0;
			O_LINE_DATA_OK <= 1'b0;
		end
		else if (settle_reg == 11'(SETTLE_SAMPLES))
			O_LINE_DATA_OK <= 1'b1;
		else if (smp_tick_reg)
			settle_reg <= settle_reg + 11'h1;
	end

	// ****************************************
	// Transmit framer and line receive buffer
	// ****************************************
	logic        buf_valid, buf_pop;
	logic [15:0] buf_data;
	logic        resp_pend_reg, resp_tag_reg, data_tag_reg;
	logic [6:0]  resp_idx_reg;
	logic [15:0] resp_data_reg;
	logic [3:0]  tx_slot_reg;
	logic [4:0]  tx_bit_reg;
	logic [19:0] tx_sh_reg;
	logic        tx_active_reg;
	logic        tx_load;
	logic [19:0] tx_next;

	assign tx_load = bclk_rise && tx_active_reg && (tx_bit_reg == 5'h0)
		&& (tx_slot_reg != SLOT_LAST);
	assign buf_pop = tx_load && (tx_slot_reg + 4'h1 == own_slot) && data_tag_reg;

	always_comb
	begin
		tx_next = 20'h0;
		if (tx_slot_reg == 4'h0 && resp_tag_reg)
			tx_next = {1'b0, resp_idx_reg, 12'h0};
		else if (tx_slot_reg == 4'h1 && resp_tag_reg)
			tx_next = {resp_data_reg, 4'h0};
		else if (tx_slot_reg + 4'h1 == own_slot && data_tag_reg)
			tx_next = {buf_data, 4'h0};
	end

	daa_pair_buffer rx_buffer (
		.i_clk       (I_CLK),
		.i_rst       (I_RST),
		.i_in_valid  (I_LINE_RX_VALID),
		.i_in_data   (I_LINE_RX_DATA),
		.o_in_ready  (O_LINE_RX_READY),
		.o_out_valid (buf_valid),
		.o_out_data  (buf_data),
		.i_out_ready (buf_pop)
	);

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			resp_pend_reg <= 1'b0;
			resp_idx_reg  <= 7'h0;
			resp_data_reg <= 16'h0;
		end
		else if (cmd_go_reg && cmd_reg.rd)
		begin
			// A new read wins over the clear of an answer already sent
			resp_pend_reg <= 1'b1;
			resp_idx_reg  <= cmd_reg.idx;
			resp_data_reg <= read_word(cmd_reg.idx);
		end
		else if (tx_load && tx_slot_reg == 4'h1 && resp_tag_reg)
			resp_pend_reg <= 1'b0;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			tx_active_reg <= 1'b0;
			tx_slot_reg   <= 4'h0;
			tx_bit_reg    <= 5'h0;
			tx_sh_reg     <= 20'h0;
			resp_tag_reg  <= 1'b0;
			data_tag_reg  <= 1'b0;
			O_SDATA_IN    <= 1'b0;
		end
		else if (sync_start)
		begin
			tx_active_reg <= 1'b1;
			tx_slot_reg   <= 4'h0;
			tx_bit_reg    <= TAG_BITS;
			resp_tag_reg  <= resp_pend_reg;
			data_tag_reg  <= O_LINE_DATA_OK && buf_valid;
			// Slot 0: ready, then tags for slots 1, 2, own data slot and 12
			tx_sh_reg     <= {1'b1, resp_pend_reg, resp_pend_reg, 1'b0, 1'b0,
				!line2_reg && O_LINE_DATA_OK && buf_valid, 4'h0,
				line2_reg && O_LINE_DATA_OK && buf_valid, 1'b0, 1'b1, 3'h0, 4'h0};
			O_SDATA_IN    <= 1'b1;
		end
		else if (bclk_rise && tx_active_reg)
		begin
			if (tx_bit_reg != 5'h0)
			begin
				O_SDATA_IN <= tx_sh_reg[18];
				tx_sh_reg  <= {tx_sh_reg[18:0], 1'b0};
				tx_bit_reg <= tx_bit_reg - 5'h1;
			end
			else if (tx_load)
			begin
				O_SDATA_IN  <= tx_next[19];
				tx_sh_reg   <= tx_next;
				tx_slot_reg <= tx_slot_reg + 4'h1;
				tx_bit_reg  <= SLOT_BITS;
			end
			else
			begin
				tx_active_reg <= 1'b0;
				O_SDATA_IN    <= 1'b0;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence wr_to(logic [6:0] idx);
		wr && cmd_reg.idx == idx;
	endsequence

	reset_quiet_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		$fell(I_RST) |-> !O_LINE_POWERED && !O_OFF_HOOK && !O_ISO_LINK_EN)
		else $error("line side active right after reset");
	soft_reset_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		wr_to(REG_RESET_IDX) |=> pr_reg == PR_RESET && own_rate == RATE_RESET)
		else $error("register reset left values");
	power_up_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		wr_to(REG_POWER_IDX) ##0 cmd_reg.data == 16'h0 |=> ##1 O_LINE_POWERED)
		else $error("zero write did not power up");
	ready_code_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		cmd_go_reg && cmd_reg.rd && cmd_reg.idx == REG_POWER_IDX && iso_en_reg
		|=> resp_data_reg[7:0] == (line2_reg ? READY_LINE2 : READY_LINE1))
		else $error("ready code wrong");
	iso_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_LINE_TX_VALID |-> O_ISO_LINK_EN && $past(pr_reg, 2) == 8'h00)
		else $error("traffic crossed before link enabled");
	frame_start_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		sync_start |=> in_frame_reg && rx_slot_reg == 4'h0 && rx_bit_reg == 5'h0f)
		else $error("frame did not restart at slot 0");
	tag_pop_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		buf_pop |-> data_tag_reg && buf_valid && O_LINE_DATA_OK)
		else $error("untagged data slot consumed a word");
	hook_follow_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		$rose(hook_cmd_reg) && iso_en_reg |=> O_OFF_HOOK)
		else $error("off-hook command not followed");
	settle_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		$rose(O_LINE_DATA_OK) |-> settle_reg == 11'(SETTLE_SAMPLES) && $past(O_OFF_HOOK))
		else $error("line data released early");
	dc_mode_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		wr_to(REG_RESET_IDX) |=> ##1 O_DC_TERM == DCT_FCC ##0 O_DC_TERM != 2'h0 [*2])
		else $error("dc termination mode invalid");
	ac_term_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		wr_to(REG_TERM_IDX) |=> ##1 O_AC_TERM == $past(cmd_reg.data[ACT_BIT], 2))
		else $error("ac termination not applied");
endmodule

// file: verilog/daa_link_pkg.sv
// Constants, types and the register indices of the line-interface codec link block
package daa_link_pkg;
	// ****************************************
	// Register indices
	// ****************************************
	localparam logic [6:0] REG_RESET_IDX    = 7'h3c;
	localparam logic [6:0] REG_POWER_IDX    = 7'h3e;
	localparam logic [6:0] REG_RATE1_IDX    = 7'h40;
	localparam logic [6:0] REG_RATE2_IDX    = 7'h42;
	localparam logic [6:0] REG_LEVEL1_IDX   = 7'h46;
	localparam logic [6:0] REG_LEVEL2_IDX   = 7'h48;
	localparam logic [6:0] REG_TERM_IDX     = 7'h5c;
	localparam logic [6:0] REG_LINELVL_IDX  = 7'h62;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int         PR_LSB           = 8;
	localparam logic [7:0] PR_RESET         = 8'hff;
	localparam logic [7:0] READY_LINE1      = 8'h0f;
	localparam logic [7:0] READY_LINE2      = 8'h33;
	localparam logic [15:0] RATE_RESET      = 16'h0000;
	localparam logic [15:0] LEVEL_RESET     = 16'h0000;
	localparam int         ACT_BIT          = 1;
	localparam int         DCT_LSB          = 2;
	localparam logic [1:0] DCT_JAPAN        = 2'h1;
	localparam logic [1:0] DCT_FCC          = 2'h2;
	localparam logic [1:0] DCT_CTR21        = 2'h3;
	localparam logic [15:0] TERM_RESET      = 16'h0008;
	localparam logic [15:0] LINELVL_RESET   = 16'h0000;
	localparam int         VOL_LSB          = 5;

	// ****************************************
	// Link framing and timing
	// ****************************************
	localparam logic [3:0] SLOT_LAST        = 4'hc;
	localparam logic [4:0] TAG_BITS         = 5'h0f;
	localparam logic [4:0] SLOT_BITS        = 5'h13;
	localparam logic [3:0] SLOT_DATA1       = 4'h5;
	localparam logic [3:0] SLOT_DATA2       = 4'ha;
	localparam int         HOOK_BIT1        = 4;
	localparam int         HOOK_BIT2        = 14;
	localparam int         CLK_HZ           = 125000000;
	localparam logic [27:0] CLK_HZ_W        = 28'(CLK_HZ);
	localparam int         OFFHOOK_SAMPLES  = 1548;
	localparam int         GROUP_DELAY_SMP  = 12;

	typedef struct packed {
		logic        rd;
		logic [6:0]  idx;
		logic [15:0] data;
	} reg_cmd_t;
endpackage

// file: verilog/daa_pair_buffer.sv
// Two-entry valid/ready buffer on the line receive data path
module daa_pair_buffer
	import daa_link_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_in_valid,
	input  wire logic [15:0] i_in_data,
	output logic             o_in_ready,
	output logic             o_out_valid,
	output logic [15:0]      o_out_data,
	input  wire logic        i_out_ready
);
	logic [15:0] slot_reg [2];
	logic        rd_ptr_reg;
	logic        wr_ptr_reg;
	logic [1:0]  count_reg;
	logic        push;
	logic        pop;

	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	assign o_out_valid = (count_reg != 2'h0);
	assign o_out_data  = slot_reg[rd_ptr_reg];

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			rd_ptr_reg <= 1'b0;
			wr_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
			o_in_ready <= 1'b1;
		end
		else
		begin
			if (push)
			begin
				slot_reg[wr_ptr_reg] <= i_in_data;
				wr_ptr_reg           <= ~wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			count_reg  <= count_reg + {1'b0, push} - {1'b0, pop};
			// Ready is registered, so it must anticipate the next count
			o_in_ready <= (count_reg + {1'b0, push} - {1'b0, pop}) != 2'h2;
		end
	end
endmodule

// file: test/daa_ctrl_model.sv
// Link controller model: clocks frames out to the device and captures its answer stream
module daa_ctrl_model
	import daa_link_pkg::*;
(
	output logic      o_bit_clk,
	output logic      o_sync,
	output logic      o_sdata,
	input  wire logic i_sdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		o_bit_clk = 1'b0;
		o_sync = 1'b0;
		o_sdata = 1'b0;
	end

	// ****************************************
	// One frame
	// ****************************************
	// Bit clock stands still between frames; SYNC moves in the low phase so the rise sees it
	task automatic run_frame(input logic cv, input reg_cmd_t c, input logic [19:0] s12,
		input logic two, input logic dv, input logic [15:0] dd, output logic [255:0] rx);
		logic [255:0] tx;
		int           n;
		int           i;
		n = two ? 10 : 5;
		tx = '0;
		tx[255] = 1'b1;
		tx[254] = cv;
		tx[253] = cv & ~c.rd;
		tx[255-n] = dv;
		tx[243] = 1'b1;
		tx[220 +: 20] = {c.rd, c.idx, 12'h0};
		tx[200 +: 20] = {c.data, 4'h0};
		tx[240-20*n +: 20] = {dd, 4'h0};
		tx[0 +: 20] = s12;
		#43;
		o_sync = 1'b1;
		for (i = 256; i >= 0; i--)
		begin
			#40;
			// Sampled just before the next rise, long after the device moved it
			if (i < 256) rx[i] = i_sdata;
			o_bit_clk = 1'b1;
			o_sdata = (i > 0) ? tx[i-1] : ~tx[0];
			#40;
			o_bit_clk = 1'b0;
			if (i == 241) o_sync = 1'b0;
		end
	endtask
endmodule

// file: test/daa_link_init_tb_top.sv
// Self-checking bench of the line-interface link block
module daa_link_init_tb_top;
	import daa_link_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// Short settle count keeps the run small; bounds below follow from it
	localparam int          SETTLE = 4;
	localparam int          HZ     = 48000;
	localparam logic [15:0] RATE   = 16'hbb80;
	// Count starts a few clocks after the hook rose, hence the margin
	localparam int          LO     = (SETTLE - 1) * CLK_HZ / HZ - 32;
	localparam int          HI     = (SETTLE + 1) * CLK_HZ / HZ;

	typedef struct packed {
		logic [6:0]  idx;
		logic [15:0] d;
		logic [1:0]  dc;
		logic        ac;
		logic [1:0]  lv;
	} row_t;

	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         two = 1'b0;
	logic         rxv = 1'b0;
	logic [15:0]  rxd = 16'h0;
	logic         bclk, sync, sdo, sdi, rx_ready, powered, iso, hook, data_ok, ac, tx_v;
	logic [1:0]   dc, lv;
	logic [15:0]  tx_d;
	logic [15:0]  tx_seen = 16'h0;
	logic [9:0]   st;
	logic [255:0] rx;
	logic [19:0]  s12 = 20'h0;
	logic         dv = 1'b0;
	logic [15:0]  dd = 16'h0;
	int           bad_count = 0;
	int           comparisons = 0;
	int           tx_cnt = 0;
	int           n;
	// Rows walk the low-voltage procedure, then CTR21 back to FCC
	row_t         rows [8] = '{
		'{REG_LINELVL_IDX, 16'h0020, 2'h2, 1'b0, 2'h1},
		'{REG_TERM_IDX, 16'h0004, 2'h1, 1'b0, 2'h1},
		'{REG_TERM_IDX, 16'h0008, 2'h2, 1'b0, 2'h1},
		'{REG_LINELVL_IDX, 16'h0000, 2'h2, 1'b0, 2'h0},
		'{REG_TERM_IDX, 16'h000e, 2'h3, 1'b1, 2'h0},
		'{REG_TERM_IDX, 16'h0002, 2'h3, 1'b1, 2'h0},
		'{REG_TERM_IDX, 16'h0008, 2'h2, 1'b0, 2'h0},
		'{REG_LINELVL_IDX, 16'h0060, 2'h2, 1'b0, 2'h3}};

	assign st = {rx_ready, powered, iso, hook, data_ok, dc, ac, lv};

	always #4 clk = ~clk;

	always @(posedge clk)
	begin
		if (tx_v === 1'b1)
		begin
			tx_seen <= tx_d;
			tx_cnt <= tx_cnt + 1;
		end
	end

	daa_link_init #(.SETTLE_SAMPLES(SETTLE)) DUT (
		.I_CLK           (clk),
		.I_RST           (rst),
		.I_BIT_CLK       (bclk),
		.I_SYNC          (sync),
		.I_SDATA_OUT     (sdo),
		.I_LINE_TWO      (two),
		.I_LINE_RX_VALID (rxv),
		.I_LINE_RX_DATA  (rxd),
		.O_LINE_RX_READY (rx_ready),
		.O_SDATA_IN      (sdi),
		.O_LINE_POWERED  (powered),
		.O_ISO_LINK_EN   (iso),
		.O_OFF_HOOK      (hook),
		.O_LINE_DATA_OK  (data_ok),
		.O_DC_TERM       (dc),
		.O_AC_TERM       (ac),
		.O_TX_LEVEL      (lv),
		.O_LINE_TX_VALID (tx_v),
		.O_LINE_TX_DATA  (tx_d)
	);

	daa_ctrl_model ctrl (
		.o_bit_clk (bclk),
		.o_sync    (sync),
		.o_sdata   (sdo),
		.i_sdata   (sdi)
	);

	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic timeout_hit();
		bad_count++;
		end_of_test();
	endtask

	function automatic logic [19:0] stx(input logic [4:0] f, input logic [1:0] c,
		input logic a, input logic [1:0] l);
		return {10'h0, f, c, a, l};
	endfunction

	// ****************************************
	// Stimulus tasks, all entered at a rising edge
	// ****************************************
	task automatic do_reset(input logic line2);
		rst <= 1'b1;
		two <= line2;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask

	task automatic frame(input logic cv, input logic r, input logic [6:0] idx,
		input logic [15:0] d);
		reg_cmd_t c;
		c = '{r, idx, d};
		ctrl.run_frame(cv, c, s12, two, dv, dd, rx);
		repeat (4) @(posedge clk);
	endtask

	task automatic wr(input logic [6:0] idx, input logic [15:0] d);
		frame(1'b1, 1'b0, idx, d);
	endtask

	// Answer arrives one frame later, so a read costs two frames
	task automatic rd(input logic [6:0] idx, input logic [15:0] exp);
		frame(1'b1, 1'b1, idx, 16'h0);
		frame(1'b0, 1'b0, 7'h0, 16'h0);
		check({rx[255:253], 17'h0}, 20'he0000);
		check(rx[220 +: 20], {1'b0, idx, 12'h0});
		check(rx[200 +: 20], {exp, 4'h0});
	endtask

	// Valid is left high on return so back-to-back words never drop it in one step
	task automatic push(input logic [15:0] w);
		int k;
		rxv <= 1'b1;
		rxd <= w;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
			if (k > 8) timeout_hit();
		end
		while (rx_ready !== 1'b1);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		@(posedge clk);
		do_reset(1'b0);
		check({10'h0, st}, stx(5'h10, 2'h2, 1'b0, 2'h0));
		rd(REG_POWER_IDX, 16'hff00);
		rd(REG_TERM_IDX, 16'h0008);
		s12 = 20'h00010;
		frame(1'b0, 1'b0, 7'h0, 16'h0);
		check({10'h0, st}, stx(5'h10, 2'h2, 1'b0, 2'h0));
		wr(REG_POWER_IDX, 16'h0000);
		check({10'h0, st}, stx(5'h18, 2'h2, 1'b0, 2'h0));
		rd(REG_POWER_IDX, 16'h0000);
		s12 = 20'h0;
		wr(REG_RATE1_IDX, RATE);
		check({10'h0, st}, stx(5'h1c, 2'h2, 1'b0, 2'h0));
		rd(REG_POWER_IDX, 16'h000f);
		for (n = 0; n < 8; n++)
		begin
			wr(rows[n].idx, rows[n].d);
			check({10'h0, st}, stx(5'h1c, rows[n].dc, rows[n].ac, rows[n].lv));
		end
		rd(7'h10, 16'h0000);
		wr(REG_RESET_IDX, 16'h5a3c);
		check({10'h0, st}, stx(5'h10, 2'h2, 1'b0, 2'h0));
		wr(REG_RATE1_IDX, RATE);
		wr(REG_POWER_IDX, 16'h0000);
		s12 = 20'h00010;
		frame(1'b0, 1'b0, 7'h0, 16'h0);
		check({10'h0, st}, stx(5'h1e, 2'h2, 1'b0, 2'h0));
		n = 0;
		while (data_ok !== 1'b1)
		begin
			@(posedge clk);
			n++;
			if (n > 20000) timeout_hit();
		end
		check({19'h0, n >= LO && n <= HI}, 20'h1);
		push(16'h1111);
		push(16'h2222);
		rxd <= 16'h3333;
		repeat (3) @(posedge clk);
		check({19'h0, rx_ready}, 20'h0);
		rxv <= 1'b0;
		dv = 1'b1;
		dd = 16'habcd;
		frame(1'b0, 1'b0, 7'h0, 16'h0);
		check({rx[250], rx[141 +: 19]}, {1'b1, 19'h08888});
		check({tx_seen, 4'h0}, {16'habcd, 4'h0});
		dv = 1'b0;
		frame(1'b0, 1'b0, 7'h0, 16'h0);
		check({rx[250], rx[141 +: 19]}, {1'b1, 19'h11110});
		check({1'b0, tx_cnt[18:0]}, 20'h1);
		frame(1'b0, 1'b0, 7'h0, 16'h0);
		check({19'h0, rx[250]}, 20'h0);
		do_reset(1'b1);
		check({10'h0, st}, stx(5'h10, 2'h2, 1'b0, 2'h0));
		wr(REG_RATE2_IDX, RATE);
		wr(REG_POWER_IDX, 16'h0000);
		rd(REG_POWER_IDX, 16'h0033);
		check({19'h0, hook}, 20'h0);
		s12 = 20'h04000;
		frame(1'b0, 1'b0, 7'h0, 16'h0);
		check({19'h0, hook}, 20'h1);
		end_of_test();
	end
endmodule
